// File: hdl/rsm_pkg.sv
// rsm_pkg: register map, control field layout, message layout and timing constants
// assumes a 100 MHz logic clock and an APB register bus with byte addresses
package rsm_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CLEAR = 8'h08;
  localparam logic [7:0] ADDR_ENABLE = 8'h0C;
  localparam logic [7:0] ADDR_STATE = 8'h10;
  // control register fields
  localparam int CTRL_W = 10;
  localparam int CTRL_NODE_LSB = 0;
  localparam int CTRL_RING_BIT = 4;
  localparam int CTRL_DUAL_BIT = 5;
  localparam int CTRL_RATE_BIT = 6;
  localparam int CTRL_BRIDGE_BIT = 7;
  localparam int CTRL_FIX_LSB = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  // status / enable bits
  localparam int EV_W = 4;
  localparam int EV_RING = 0;
  localparam int EV_OFFLINE = 1;
  localparam int EV_DROP = 2;
  localparam int EV_RETURN = 3;
  localparam logic [EV_W-1:0] EV_RST = 4'h0;
  // state register: ring break in bit 0, offline flags from bit 16
  localparam int STATE_OFF_LSB = 16;
  // message word: sender node and output states
  localparam int MSG_NODE_LSB = 16;
  localparam int NODE_W = 4;
  localparam int NPEER = 16;
  // timing
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned MSG_BITS = 160;
  localparam longint unsigned RATE_LO_BPS = 64_000;
  localparam longint unsigned RATE_HI_BPS = 128_000;
  localparam longint unsigned INTEG_MS = 1000;
  localparam longint unsigned TMO_MS = 2000;
  localparam longint unsigned SLOT_LO_CYC = MSG_BITS * CLK_HZ / RATE_LO_BPS;
  localparam longint unsigned SLOT_HI_CYC = MSG_BITS * CLK_HZ / RATE_HI_BPS;
  localparam longint unsigned INTEG_CYC = INTEG_MS * CLK_HZ / 1000;
  localparam longint unsigned TMO_CYC = TMO_MS * CLK_HZ / 1000;
endpackage : rsm_pkg

// File: hdl/rsm_ring_messaging.sv
// rsm_ring_messaging: status message framer for a one- or two-channel ring link
// assumes word-wide link channels, one message per valid cycle, and an APB master
// Contract
// [RULE1] dual-channel card sends every own message on both channels together; the code sends on each channel when that channel's own slot counter is free
// [RULE2] single-channel card sends own messages on channel 0 only
// [RULE3] received messages from other nodes are forwarded onward
// [RULE4] integrity message sent at least every 1000 ms without changes
// [RULE5] output change queues a message at once unless bandwidth is used up
// [RULE6] in ring mode own messages must return, else ring break flag
// [RULE7] one offline flag per each of 16 peers when their messages stop
// [RULE8] every own message carries the configured node number
// [RULE9] every node on a ring has a unique node number
// [RULE10] fiber back-to-back may run 128 kbps, others 64 kbps
// [RULE11] all nodes on a link use the same data rate
// [RULE12] one rate setting applies to both channels
// [RULE13] each hop delays about one message slot at the chosen rate
// [RULE14] channels marked fixed-rate always run 64 kbps
// [RULE15] crossover passes channel 0 receptions to channel 1
// [RULE16] missing-message timeout is longer than the integrity interval
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module rsm_ring_messaging #(
  parameter int unsigned SLOT_LO = int'(rsm_pkg::SLOT_LO_CYC),
  parameter int unsigned SLOT_HI = int'(rsm_pkg::SLOT_HI_CYC),
  parameter int unsigned INTEG = int'(rsm_pkg::INTEG_CYC),
  parameter int unsigned TMO = int'(rsm_pkg::TMO_CYC)
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scan_pass,
  input wire logic [15:0] out_state,
  input wire logic [1:0] ch_rx_valid,
  input wire logic [1:0][31:0] ch_rx_data,
  output logic [1:0] ch_tx_valid,
  output logic [1:0][31:0] ch_tx_data,
  output logic ring_break,
  output logic [15:0] peer_offline,
  output logic irq
);
  localparam int SLOT_W = $clog2(SLOT_LO + 1);
  localparam int TMO_W = $clog2(TMO + 1);
  localparam logic [SLOT_W-1:0] SLOT_LO_C = SLOT_W'(SLOT_LO);
  localparam logic [SLOT_W-1:0] SLOT_HI_C = SLOT_W'(SLOT_HI);
  localparam logic [TMO_W-1:0] INTEG_C = TMO_W'(INTEG);
  localparam logic [TMO_W-1:0] TMO_C = TMO_W'(TMO);

  typedef struct packed {
    logic [rsm_pkg::CTRL_W-1:0] ctrl;
    logic [rsm_pkg::EV_W-1:0] sts;
    logic [rsm_pkg::EV_W-1:0] ena;
    logic [1:0] own_pend;
    logic [1:0] fwd_pend;
    logic [1:0][31:0] fwd_msg;
    logic [1:0][SLOT_W-1:0] slot;
    logic [TMO_W-1:0] integ;
    logic [TMO_W-1:0] ret;
    logic [rsm_pkg::NPEER-1:0][TMO_W-1:0] peer;
    logic [15:0] last_state;
    logic [1:0] tx_valid;
    logic [1:0][31:0] tx_data;
    logic ring_break;
    logic [15:0] offline;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rsm_state_t;

  rsm_state_t q;
  rsm_state_t d;

  logic [3:0] node;
  logic ring_en;
  logic dual;
  logic rate_hi;
  logic bridge;
  logic [1:0] fix64;
  assign node = q.ctrl[rsm_pkg::CTRL_NODE_LSB +: rsm_pkg::NODE_W];
  assign ring_en = q.ctrl[rsm_pkg::CTRL_RING_BIT];
  assign dual = q.ctrl[rsm_pkg::CTRL_DUAL_BIT];
  assign rate_hi = q.ctrl[rsm_pkg::CTRL_RATE_BIT];
  assign bridge = q.ctrl[rsm_pkg::CTRL_BRIDGE_BIT];
  assign fix64 = q.ctrl[rsm_pkg::CTRL_FIX_LSB +: 2];

  // message slot length of one channel; fixed-rate channels ignore the rate bit
  function automatic logic [SLOT_W-1:0] slot_len(input logic hi, input logic fixed);
    slot_len = (hi && !fixed) ? SLOT_HI_C : SLOT_LO_C; // see [RULE10] see [RULE14]
  endfunction : slot_len

  function automatic logic [3:0] src_of(input logic [31:0] msg);
    src_of = msg[rsm_pkg::MSG_NODE_LSB +: rsm_pkg::NODE_W];
  endfunction : src_of

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [rsm_pkg::EV_W-1:0] ev;
    logic [rsm_pkg::EV_W-1:0] clr;
    logic [1:0] on;
    logic acc;
    ev = '0;
    clr = '0;
    on = {dual, 1'b1}; // see [RULE1] see [RULE2]
    acc = psel && penable;
    d = q;
    d.tx_valid = '0;
    // transmit first so that triggers below win over the pending clear
    for (int c = 0; c < 2; c++) begin
      if (q.slot[c] != '0) begin
        d.slot[c] = q.slot[c] - 1'b1;
      end else if (on[c] && q.own_pend[c]) begin
        d.tx_valid[c] = 1'b1;
        d.tx_data[c] = {12'h000, node, q.last_state}; // see [RULE8]
        d.own_pend[c] = 1'b0;
        d.slot[c] = slot_len(rate_hi, fix64[c]); // see [RULE12]
      end else if (on[c] && q.fwd_pend[c]) begin
        // forwarded traffic waits for a free slot: one slot of delay per hop
        d.tx_valid[c] = 1'b1; // see [RULE13]
        d.tx_data[c] = q.fwd_msg[c];
        d.fwd_pend[c] = 1'b0;
        d.slot[c] = slot_len(rate_hi, fix64[c]);
      end
    end
    // integrity and change triggers restart the integrity interval
    if (q.integ != '0) begin
      d.integ = q.integ - 1'b1;
    end
    if (q.integ == '0) begin
      d.own_pend = on; // see [RULE4]
      d.integ = INTEG_C;
    end
    if (scan_pass && out_state != q.last_state) begin
      // a change already waiting is merged into one message of the newest state
      d.own_pend = on; // see [RULE5]
      d.last_state = out_state;
      d.integ = INTEG_C;
    end
    // silence counters saturate at the timeout
    if (ring_en && q.ret != TMO_C) begin
      d.ret = q.ret + 1'b1;
    end else if (!ring_en) begin
      d.ret = '0;
    end
    for (int p = 0; p < rsm_pkg::NPEER; p++) begin
      if (q.peer[p] != TMO_C) begin
        d.peer[p] = q.peer[p] + 1'b1;
      end
    end
    // reception, forwarding and crossover
    for (int c = 0; c < 2; c++) begin
      if (ch_rx_valid[c]) begin
        if (src_of(ch_rx_data[c]) == node) begin
          ev[rsm_pkg::EV_RETURN] = 1'b1;
          d.ret = '0; // see [RULE6]
        end else begin
          d.peer[src_of(ch_rx_data[c])] = '0; // see [RULE7]
          ev[rsm_pkg::EV_DROP] = ev[rsm_pkg::EV_DROP] | d.fwd_pend[c];
          d.fwd_pend[c] = 1'b1; // see [RULE3]
          d.fwd_msg[c] = ch_rx_data[c];
          if (c == 0 && bridge && dual) begin
            ev[rsm_pkg::EV_DROP] = ev[rsm_pkg::EV_DROP] | d.fwd_pend[1];
            d.fwd_pend[1] = 1'b1; // see [RULE15]
            d.fwd_msg[1] = ch_rx_data[0];
          end
        end
      end
    end
    d.ring_break = ring_en && (d.ret == TMO_C); // see [RULE6] see [RULE16]
    for (int p = 0; p < rsm_pkg::NPEER; p++) begin
      d.offline[p] = (d.peer[p] == TMO_C); // see [RULE7] see [RULE16]
    end
    ev[rsm_pkg::EV_RING] = d.ring_break && !q.ring_break;
    ev[rsm_pkg::EV_OFFLINE] = |(d.offline & ~q.offline);
    // apb: one wait cycle, write commits at the edge that samples pready
    d.pready = acc && !q.pready;
    d.pslverr = 1'b0;
    d.prdata = '0;
    if (acc && !q.pready) begin
      case (paddr)
        rsm_pkg::ADDR_CTRL: d.prdata = 32'(q.ctrl);
        rsm_pkg::ADDR_STATUS: d.prdata = 32'(q.sts);
        rsm_pkg::ADDR_CLEAR: d.prdata = '0;
        rsm_pkg::ADDR_ENABLE: d.prdata = 32'(q.ena);
        rsm_pkg::ADDR_STATE: d.prdata = {q.offline, 15'h0000, q.ring_break};
        default: d.pslverr = 1'b1;
      endcase
    end
    if (acc && q.pready && pwrite) begin
      case (paddr)
        rsm_pkg::ADDR_CTRL: d.ctrl = pwdata[rsm_pkg::CTRL_W-1:0];
        rsm_pkg::ADDR_CLEAR: clr = pwdata[rsm_pkg::EV_W-1:0];
        rsm_pkg::ADDR_ENABLE: d.ena = pwdata[rsm_pkg::EV_W-1:0];
        default: ;
      endcase
    end
    // a new event wins over a clear in the same cycle
    d.sts = (q.sts & ~clr) | ev;
    d.irq = |(d.sts & d.ena);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.ctrl <= rsm_pkg::CTRL_RST;
      q.sts <= rsm_pkg::EV_RST;
      q.ena <= rsm_pkg::EV_RST;
      q.integ <= INTEG_C;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign ch_tx_valid = q.tx_valid;
  assign ch_tx_data = q.tx_data;
  assign ring_break = q.ring_break;
  assign peer_offline = q.offline;
  assign irq = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_both_ready;
    dual && q.own_pend == 2'b11 && q.slot == '0;
  endsequence
  sequence s_change;
    scan_pass && out_state != q.last_state;
  endsequence

  AST_DUAL_BOTH: assert property (@(posedge clock) disable iff (reset) // see [RULE1]
    s_both_ready |=> ch_tx_valid == 2'b11)
    else $error("own message not sent on both channels");
  AST_SINGLE_CH0: assert property (@(posedge clock) disable iff (reset) // see [RULE2]
    ch_tx_valid[1] |-> $past(dual))
    else $error("channel 1 used on single-channel card");
  AST_FORWARD: assert property (@(posedge clock) disable iff (reset) // see [RULE3]
    ch_rx_valid[0] && src_of(ch_rx_data[0]) != node |=> q.fwd_pend[0])
    else $error("foreign message not queued for forwarding");
  AST_INTEGRITY: assert property (@(posedge clock) disable iff (reset) // see [RULE4]
    q.integ == '0 |=> q.own_pend[0] && q.integ == INTEG_C)
    else $error("integrity message not scheduled");
  AST_CHANGE: assert property (@(posedge clock) disable iff (reset) // see [RULE5]
    s_change |=> q.own_pend[0] && q.last_state == $past(out_state))
    else $error("state change not queued");
  AST_RING_BREAK: assert property (@(posedge clock) disable iff (reset) // see [RULE6]
    ring_en && q.ret == TMO_C && !ch_rx_valid[0] && !ch_rx_valid[1] |=> ring_break)
    else $error("ring break not raised after timeout");
  AST_PEER_SEEN: assert property (@(posedge clock) disable iff (reset) // see [RULE7]
    ch_rx_valid[0] && src_of(ch_rx_data[0]) != node
      |=> q.peer[$past(src_of(ch_rx_data[0]))] == '0 ##1 !peer_offline[$past(src_of(ch_rx_data[0]), 2)])
    else $error("peer reception did not clear offline");
  AST_NODE_TAG: assert property (@(posedge clock) disable iff (reset) // see [RULE8]
    ch_tx_valid[0] && !$past(q.fwd_pend[0] && !q.own_pend[0])
      |-> src_of(ch_tx_data[0]) == $past(node))
    else $error("own message lacks node number");
  AST_RATE: assert property (@(posedge clock) disable iff (reset) // see [RULE10]
    ch_tx_valid[0] |-> q.slot[0] == slot_len($past(rate_hi), $past(fix64[0])))
    else $error("slot length does not match rate");
  AST_BRIDGE: assert property (@(posedge clock) disable iff (reset) // see [RULE15]
    dual && bridge && ch_rx_valid[0] && src_of(ch_rx_data[0]) != node |=> q.fwd_pend[1])
    else $error("crossover did not pass message to channel 1");

  // timing, data and flag guards
  AST_SLOT_QUIET: assert property (@(posedge clock) disable iff (reset) // see [RULE13]
    q.slot[0] != '0 |=> !ch_tx_valid[0])
    else $error("message sent inside a busy slot");
  AST_RATE_CH1: assert property (@(posedge clock) disable iff (reset) // see [RULE12]
    ch_tx_valid[1] |-> q.slot[1] == slot_len($past(rate_hi), $past(fix64[1])))
    else $error("channel 1 slot length does not match rate");
  AST_FIXED_LO: assert property (@(posedge clock) disable iff (reset) // see [RULE14]
    ch_tx_valid[0] && $past(fix64[0]) |-> q.slot[0] == SLOT_LO_C)
    else $error("fixed-rate channel not at low rate");
  AST_NO_RING: assert property (@(posedge clock) disable iff (reset) // see [RULE6]
    !ring_en |=> !ring_break)
    else $error("ring break raised outside ring mode");
  AST_RING_TMO: assert property (@(posedge clock) disable iff (reset) // see [RULE16]
    $rose(ring_break) |-> q.ret == TMO_C)
    else $error("ring break raised before timeout");
  for (genvar g = 0; g < rsm_pkg::NPEER; g++) begin : g_peer_tmo
    AST_PEER_TMO: assert property (@(posedge clock) disable iff (reset) // see [RULE16]
      $rose(peer_offline[g]) |-> q.peer[g] == TMO_C)
      else $error("peer marked offline before timeout");
  end
  AST_FWD_DATA: assert property (@(posedge clock) disable iff (reset) // see [RULE3]
    ch_tx_valid[0] && $past(q.fwd_pend[0] && !q.own_pend[0])
      |-> ch_tx_data[0] == $past(q.fwd_msg[0]))
    else $error("forwarded word altered");
  AST_OWN_NOT_FWD: assert property (@(posedge clock) disable iff (reset) // see [RULE3]
    ch_rx_valid[0] && src_of(ch_rx_data[0]) == node && !q.fwd_pend[0] |=> !q.fwd_pend[0])
    else $error("own returned message queued for forwarding");
  AST_BRIDGE_DATA: assert property (@(posedge clock) disable iff (reset) // see [RULE15]
    dual && bridge && ch_rx_valid == 2'b01 && src_of(ch_rx_data[0]) != node
      |=> q.fwd_msg[1] == $past(ch_rx_data[0]))
    else $error("crossover word altered");
  AST_CH1_TAG: assert property (@(posedge clock) disable iff (reset) // see [RULE8]
    ch_tx_valid[1] && !$past(q.fwd_pend[1] && !q.own_pend[1])
      |-> src_of(ch_tx_data[1]) == $past(node))
    else $error("own message on channel 1 lacks node number");
endmodule : rsm_ring_messaging

// File: verif/rsm_peer_model.sv
// rsm_peer_model: far side of the ring link, standing in for the other relays
// assumes word-wide channels; the block's own words come back, other words end here
`timescale 1ns/1ns
module rsm_peer_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic loop_en,
  input wire logic [3:0] home_node,
  input wire logic inj_valid,
  input wire logic [31:0] inj_data,
  input wire logic [1:0] tx_valid,
  input wire logic [1:0][31:0] tx_data,
  output logic [1:0] rx_valid,
  output logic [1:0][31:0] rx_data
);
  ////////////////////////////////////////////////////////////////////////////////
  // one rate for every node; words from other senders stop at their origin
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_valid <= 2'b00;
      rx_data <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        rx_valid[c] <= 1'b0;
        // idle data toggles so a stale word is never mistaken for a fresh one
        rx_data[c] <= ~rx_data[c];
        if (tx_valid[c] && loop_en && tx_data[c][19:16] == home_node) begin
          rx_valid[c] <= 1'b1;
          rx_data[c] <= tx_data[c];
        end
      end
      if (inj_valid) begin
        rx_valid[0] <= 1'b1;
        rx_data[0] <= inj_data;
      end
    end
  end
endmodule : rsm_peer_model

// File: verif/tb_top.sv
// tb_top: self-checking bench for the ring status messaging block
// assumes rsm_peer_model on the link side; short sim counts replace real ones
`timescale 1ns/1ns
module tb_top;
  localparam int SLO = 40;
  localparam int SHI = 20;
  localparam int IG = 300;
  localparam int TMO = 700;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, scan_pass = 1'b0;
  logic pready, pslverr, ring_break, irq, err_b;
  logic loop_en = 1'b1, inj_valid = 1'b0, dual = 1'b0, rate = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd_w, own_w = 32'h0000_0000;
  logic [31:0] inj_data = 32'h0000_0000;
  logic [15:0] out_state = 16'h0000, peer_offline;
  logic [1:0] rx_v, tx_v, fix = 2'b00;
  logic [1:0][31:0] rx_d, tx_d;
  logic [31:0] exp_q[2][$];
  int n_errors = 0, tests_run = 0, n_integ = 0, cyc = 0, p;
  int last[2] = '{-1000, -1000};
  int gap[2];
  integer seed = 32'hdc14_20ae;
  always #5 clock = ~clock;
  rsm_ring_messaging #(.SLOT_LO(SLO), .SLOT_HI(SHI), .INTEG(IG), .TMO(TMO)) dut (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scan_pass(scan_pass), .out_state(out_state), .ch_rx_valid(rx_v), .ch_rx_data(rx_d),
    .ch_tx_valid(tx_v), .ch_tx_data(tx_d), .ring_break(ring_break),
    .peer_offline(peer_offline), .irq(irq));
  rsm_peer_model peer (
    .clock(clock), .reset(reset), .loop_en(loop_en), .home_node(own_w[19:16]),
    .inj_valid(inj_valid), .inj_data(inj_data), .tx_valid(tx_v), .tx_data(tx_d),
    .rx_valid(rx_v), .rx_data(rx_d));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic int slot(input int c);
    return (rate && !fix[c]) ? SHI : SLO;
  endfunction : slot
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // access holds until pready is seen high at a rising edge; the watchdog bounds it
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd_w = prdata;
    err_b = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never reassigns psel in this time step
    @(posedge clock);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd_w & m, e);
    chk({31'h0, err_b}, {31'h0, ee});
  endtask : rd
  task automatic setc(input logic [9:0] v);
    own_w[19:16] = v[3:0];
    dual = v[5];
    rate = v[6];
    fix = v[9:8];
    apb(1'b1, rsm_pkg::ADDR_CTRL, {22'h0, v});
  endtask : setc
  task automatic change();
    out_state <= 16'($random(seed));
    scan_pass <= 1'b1;
    @(posedge clock);
    scan_pass <= 1'b0;
    own_w[15:0] = out_state;
    exp_q[0].push_back(own_w);
    if (dual) exp_q[1].push_back(own_w);
  endtask : change
  task automatic drain();
    int n;
    n = 0;
    while (exp_q[0].size() + exp_q[1].size() > 0 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    chk({31'h0, n < 3000}, 32'h1);
    // let the slot counters run out before the rate may change
    repeat (45) @(posedge clock);
  endtask : drain
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  // words with nothing queued are integrity repeats of the last own word
  always @(posedge clock) begin
    cyc++;
    for (int c = 0; c < 2; c++) begin
      if (tx_v[c] === 1'b1) begin
        gap[c] = cyc - last[c];
        last[c] = cyc;
        chk({31'h0, gap[c] > slot(c)}, 32'h1);
        if (exp_q[c].size() > 0) chk(tx_d[c], exp_q[c].pop_front());
        else begin
          n_integ++;
          chk(tx_d[c], (c == 1 && !dual) ? 32'hffff_ffff : own_w);
        end
      end
    end
  end
  initial begin
    repeat (10000) @(posedge clock);
    n_errors++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(rsm_pkg::ADDR_CTRL, 32'hffff_ffff, 32'h0000_0000, 1'b0);
    rd(rsm_pkg::ADDR_ENABLE, 32'hffff_ffff, 32'h0000_0000, 1'b0);
    rd(8'h20, 32'hffff_ffff, 32'h0000_0000, 1'b1);
    for (int k = 0; k < 3; k++) begin
      setc(k == 0 ? 10'h035 : (k == 1 ? 10'h075 : 10'h375));
      change();
      repeat (2) @(posedge clock);
      change();
      drain();
      chk({31'h0, gap[0] <= slot(0) + 3}, 32'h1);
      chk({31'h0, gap[1] <= slot(1) + 3}, 32'h1);
    end
    setc(10'h0b5);
    inj_data <= {12'h000, 4'h3, 16'($random(seed))};
    inj_valid <= 1'b1;
    @(posedge clock);
    inj_valid <= 1'b0;
    exp_q[0].push_back(inj_data);
    exp_q[1].push_back(inj_data);
    drain();
    setc(10'h015);
    change();
    drain();
    p = n_integ;
    repeat (IG + SLO) @(posedge clock);
    chk({31'h0, n_integ > p}, 32'h1);
    chk({31'h0, peer_offline[3]}, 32'h0);
    repeat (TMO - IG) @(posedge clock);
    chk({31'h0, peer_offline[3]}, 32'h1);
    apb(1'b1, rsm_pkg::ADDR_CLEAR, 32'h0000_000f);
    loop_en <= 1'b0;
    p = 0;
    while (ring_break !== 1'b1 && p < 1500) begin
      @(posedge clock);
      p++;
    end
    chk({31'h0, ring_break}, 32'h1);
    rd(rsm_pkg::ADDR_STATUS, 32'h0000_0001, 32'h0000_0001, 1'b0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, rsm_pkg::ADDR_ENABLE, 32'h0000_0001);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, rsm_pkg::ADDR_CLEAR, 32'h0000_0001);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    rd(rsm_pkg::ADDR_STATE, 32'h0000_0001, 32'h0000_0001, 1'b0);
    // leaving ring mode must drop the break flag
    setc(10'h005);
    repeat (2) @(posedge clock);
    chk({31'h0, ring_break}, 32'h0);
    wrap_up();
  end
endmodule : tb_top
